// ---- design/apbi_cmd_core.sv ----
// Drive-side handler for power, buffer and identify commands.
// Assumes the task-file decoder presents one accepted command as a one-cycle valid.
// Functional notes
// - Standby command codes E2h or 96h put the drive into standby.
// - Standby or idle with a count other than 00h or FEh enables and loads the standby timer.
// - Standby or idle with zero count disables the standby timer.
// - Codes 1-240 give five-second steps; 241-251 give thirty-minute steps.
// - Code 252 is 21 min, 253 is 8-12 h, 255 is 21 min 15 s.
// - Timer expiry moves the drive to standby with the spindle stopped.
// - Disk access in standby spins the spindle up, then runs the access.
// - After such an access the standby timer is reloaded and restarts.
// - Idle command codes E3h or 97h put the drive into idle.
// - Check power mode returns 00h in standby, FFh when idle; it is refused while spinning up.
// - Sleep command enters sleep at once and raises a completion interrupt in the same cycle.
// - Only a reset leaves sleep: after dev_reset the drive is in standby, after sys_rst it spins up to idle.
// - Read buffer sets busy, prepares one sector, sets data request, interrupts.
// - Write buffer prepares one sector for writing, then sets data request.
// - Identify sets busy, fills the buffer, sets data request and interrupts.
// - Identify word 0 reads 0040h: fixed, non-removable ATA device.
// - Words 10-19 serial, 23-26 firmware revision, 27-46 model string.
// - Identify word 47 reads 8010h.
// - Identify word 49 reads 2F00h.
// - Identify word 53 reads 0007h.
// - Power-on spins up to idle; ready stays set in idle and standby.
`timescale 1ns/1ps
module apbi_cmd_core #(
  parameter int unsigned SEC_CYCLES = apbi_pkg::SEC_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic dev_reset,
  input wire apbi_pkg::apbi_cmd_s cmd,
  input wire logic [7:0] buf_sector,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [15:0] wr_data,
  input wire logic disk_req,
  input wire logic disk_done,
  input wire logic spin_ready,
  output apbi_pkg::apbi_stat_s stat,
  output logic [7:0] sc_out,
  output logic [15:0] rd_data,
  output logic spindle_on,
  output logic disk_go,
  output apbi_pkg::apbi_pm_e pm
);
  apbi_pkg::apbi_state_e st_reg, st_next;
  apbi_pkg::apbi_pm_e pm_reg, pm_next;
  apbi_pkg::apbi_stat_s stat_reg, stat_next;
  logic [7:0] sc_reg, sc_next;
  logic [15:0] rdd_reg, rdd_next;
  logic spin_reg, spin_next;
  logic go_reg, go_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] sec_reg, sec_next;
  logic [31:0] div_reg, div_next;
  logic tick_reg, tick_next;
  logic tmr_set, tmr_restart, tmr_run, tmr_expire;
  logic mem_we;
  logic [15:0] mem_wd;
  logic [15:0] id_word;
  logic [15:0] mem [0:apbi_pkg::BUF_WORDS-1];
  logic take;
  logic is_stby, is_idle, is_chkp, is_sleep;

  // One-second enable for the standby timer
  always_comb begin
    div_next = div_reg + 32'h0000_0001;
    tick_next = 1'b0;
    if (div_reg == 32'(SEC_CYCLES - 1)) begin
      div_next = 32'h0000_0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  apbi_sby_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .set(tmr_set),
    .code(cmd.count),
    .restart(tmr_restart),
    .run(tmr_run),
    .sec_tick(tick_reg),
    .expire(tmr_expire)
  );

  apbi_ident_rom u_rom (
    .idx(ptr_reg),
    .word(id_word)
  );

  // Commands are refused while busy, in a transfer, or asleep
  assign take = cmd.valid && st_reg == apbi_pkg::ST_READY && pm_reg != apbi_pkg::PM_SLEEP;
  assign is_stby = cmd.code == apbi_pkg::CMD_STBY_A || cmd.code == apbi_pkg::CMD_STBY_B;
  assign is_idle = cmd.code == apbi_pkg::CMD_IDLE_A || cmd.code == apbi_pkg::CMD_IDLE_B;
  assign is_chkp = cmd.code == apbi_pkg::CMD_CHKP_A || cmd.code == apbi_pkg::CMD_CHKP_B;
  assign is_sleep = cmd.code == apbi_pkg::CMD_SLEEP_A || cmd.code == apbi_pkg::CMD_SLEEP_B;
  assign tmr_set = take && (is_stby || is_idle);
  assign tmr_run = pm_reg == apbi_pkg::PM_IDLE && st_reg == apbi_pkg::ST_READY;

  always_comb begin
    st_next = st_reg;
    pm_next = pm_reg;
    stat_next = stat_reg;
    stat_next.intrq = 1'b0;
    stat_next.drdy = pm_reg != apbi_pkg::PM_SLEEP;
    sc_next = sc_reg;
    rdd_next = rdd_reg;
    spin_next = spin_reg;
    go_next = 1'b0;
    ptr_next = ptr_reg;
    sec_next = sec_reg;
    tmr_restart = 1'b0;
    mem_we = 1'b0;
    mem_wd = wr_data;
    case (st_reg)
      apbi_pkg::ST_READY: begin
        if (pm_reg == apbi_pkg::PM_SLEEP) begin
          if (dev_reset) begin
            pm_next = apbi_pkg::PM_STANDBY;
          end
        end else if (take && is_stby) begin
          pm_next = apbi_pkg::PM_STANDBY;
          spin_next = 1'b0;
          sc_next = apbi_pkg::SC_DONE;
          stat_next.intrq = 1'b1;
        end else if (take && is_idle) begin
          sc_next = apbi_pkg::SC_DONE;
          if (pm_reg == apbi_pkg::PM_IDLE) begin
            stat_next.intrq = 1'b1;
          end else begin
            pm_next = apbi_pkg::PM_SPINUP;
            spin_next = 1'b1;
            stat_next.bsy = 1'b1;
            st_next = apbi_pkg::ST_SPINUP;
          end
        end else if (take && is_chkp) begin
          sc_next = (pm_reg == apbi_pkg::PM_IDLE) ? apbi_pkg::SC_PM_IDLE : apbi_pkg::SC_PM_LOW;
          stat_next.intrq = 1'b1;
        end else if (take && is_sleep) begin
          pm_next = apbi_pkg::PM_SLEEP;
          spin_next = 1'b0;
          sc_next = apbi_pkg::SC_DONE;
          stat_next.intrq = 1'b1;
        end else if (take && (cmd.code == apbi_pkg::CMD_RDBUF || cmd.code == apbi_pkg::CMD_IDENT)) begin
          stat_next.bsy = 1'b1;
          ptr_next = 8'h00;
          sc_next = apbi_pkg::SC_DONE;
          if (cmd.code == apbi_pkg::CMD_IDENT) begin
            sec_next = apbi_pkg::IDENT_SECTOR;
            st_next = apbi_pkg::ST_FILL;
          end else begin
            sec_next = buf_sector;
            st_next = apbi_pkg::ST_PREP;
          end
        end else if (take && cmd.code == apbi_pkg::CMD_WRBUF) begin
          sec_next = buf_sector;
          ptr_next = 8'h00;
          sc_next = apbi_pkg::SC_DONE;
          stat_next.drq = 1'b1;
          st_next = apbi_pkg::ST_DRQ_WR;
        end else if (tmr_expire && pm_reg == apbi_pkg::PM_IDLE) begin
          pm_next = apbi_pkg::PM_STANDBY;
          spin_next = 1'b0;
        end else if (disk_req && !cmd.valid) begin
          stat_next.bsy = 1'b1;
          if (pm_reg == apbi_pkg::PM_IDLE) begin
            go_next = 1'b1;
            st_next = apbi_pkg::ST_DISK;
          end else begin
            pm_next = apbi_pkg::PM_SPINUP;
            spin_next = 1'b1;
            st_next = apbi_pkg::ST_SPINUP;
          end
        end
      end
      apbi_pkg::ST_SPINUP: begin
        // Shared by power-on, idle command and disk access
        if (spin_ready) begin
          pm_next = apbi_pkg::PM_IDLE;
          if (disk_req) begin
            go_next = 1'b1;
            st_next = apbi_pkg::ST_DISK;
          end else begin
            stat_next.bsy = 1'b0;
            stat_next.intrq = 1'b1;
            tmr_restart = 1'b1;
            st_next = apbi_pkg::ST_READY;
          end
        end
      end
      apbi_pkg::ST_DISK: begin
        if (disk_done) begin
          tmr_restart = 1'b1;
          stat_next.bsy = 1'b0;
          st_next = apbi_pkg::ST_READY;
        end
      end
      apbi_pkg::ST_FILL: begin
        mem_we = 1'b1;
        mem_wd = id_word;
        ptr_next = ptr_reg + 8'h01;
        if (ptr_reg == apbi_pkg::LAST_WORD) begin
          st_next = apbi_pkg::ST_PREP;
        end
      end
      apbi_pkg::ST_PREP: begin
        // First word is staged so the first host strobe sees it
        rdd_next = mem[{sec_reg, ptr_reg}];
        stat_next.bsy = 1'b0;
        stat_next.drq = 1'b1;
        stat_next.intrq = 1'b1;
        st_next = apbi_pkg::ST_DRQ_RD;
      end
      apbi_pkg::ST_DRQ_RD: begin
        if (rd_stb) begin
          ptr_next = ptr_reg + 8'h01;
          rdd_next = mem[{sec_reg, 8'(ptr_reg + 8'h01)}];
          if (ptr_reg == apbi_pkg::LAST_WORD) begin
            stat_next.drq = 1'b0;
            st_next = apbi_pkg::ST_READY;
          end
        end
      end
      apbi_pkg::ST_DRQ_WR: begin
        if (wr_stb) begin
          mem_we = 1'b1;
          ptr_next = ptr_reg + 8'h01;
          if (ptr_reg == apbi_pkg::LAST_WORD) begin
            stat_next.drq = 1'b0;
            stat_next.intrq = 1'b1;
            st_next = apbi_pkg::ST_READY;
          end
        end
      end
      default: st_next = apbi_pkg::ST_READY;
    endcase
  end

  // Buffer has no reset; its contents are undefined until written
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[{sec_reg, ptr_reg}] <= mem_wd;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= apbi_pkg::ST_SPINUP;
      pm_reg <= apbi_pkg::PM_SPINUP;
      stat_reg <= 4'b1100;
      sc_reg <= 8'h00;
      rdd_reg <= 16'h0000;
      spin_reg <= 1'b1;
      go_reg <= 1'b0;
      ptr_reg <= 8'h00;
      sec_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      pm_reg <= pm_next;
      stat_reg <= stat_next;
      sc_reg <= sc_next;
      rdd_reg <= rdd_next;
      spin_reg <= spin_next;
      go_reg <= go_next;
      ptr_reg <= ptr_next;
      sec_reg <= sec_next;
    end
  end

  assign stat = stat_reg;
  assign sc_out = sc_reg;
  assign rd_data = rdd_reg;
  assign spindle_on = spin_reg;
  assign disk_go = go_reg;
  assign pm = pm_reg;

  sequence s_ready_pulse;
    !stat_reg.bsy && stat_reg.drq && stat_reg.intrq;
  endsequence

  AST_STBY: assert property (@(posedge clk) disable iff (sys_rst)
    take && is_stby |=> pm_reg == apbi_pkg::PM_STANDBY && !spin_reg && stat_reg.intrq)
    else $error("Standby command did not reach standby");
  AST_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
    take && is_idle && pm_reg == apbi_pkg::PM_STANDBY |=> pm_reg == apbi_pkg::PM_SPINUP && spin_reg)
    else $error("Idle command did not spin up");
  AST_CHKP: assert property (@(posedge clk) disable iff (sys_rst)
    take && is_chkp |=> sc_reg == (($past(pm_reg) == apbi_pkg::PM_IDLE) ? 8'hFF : 8'h00))
    else $error("Check power mode answer wrong");
  AST_SLEEP: assert property (@(posedge clk) disable iff (sys_rst)
    take && is_sleep |=> pm_reg == apbi_pkg::PM_SLEEP && stat_reg.intrq ##1 !stat_reg.drdy)
    else $error("Sleep entry wrong");
  AST_WAKE: assert property (@(posedge clk) disable iff (sys_rst)
    pm_reg == apbi_pkg::PM_SLEEP |=> pm_reg == ($past(dev_reset) ? apbi_pkg::PM_STANDBY : apbi_pkg::PM_SLEEP))
    else $error("Sleep left without reset");
  AST_RDBUF: assert property (@(posedge clk) disable iff (sys_rst)
    take && cmd.code == apbi_pkg::CMD_RDBUF |=> stat_reg.bsy && !stat_reg.drq ##1 s_ready_pulse)
    else $error("Read buffer handshake wrong");
  AST_IDENT: assert property (@(posedge clk) disable iff (sys_rst)
    take && cmd.code == apbi_pkg::CMD_IDENT |=> stat_reg.bsy[*8] ##[250:252] s_ready_pulse)
    else $error("Identify handshake wrong");
  AST_WRBUF: assert property (@(posedge clk) disable iff (sys_rst)
    take && cmd.code == apbi_pkg::CMD_WRBUF |=> stat_reg.drq && !stat_reg.bsy)
    else $error("Write buffer data request missing");
  AST_EXPIRE: assert property (@(posedge clk) disable iff (sys_rst)
    tmr_expire && st_reg == apbi_pkg::ST_READY && pm_reg == apbi_pkg::PM_IDLE && !cmd.valid
    |=> pm_reg == apbi_pkg::PM_STANDBY && !spin_reg)
    else $error("Timer expiry did not stop spindle");
  AST_DISK: assert property (@(posedge clk) disable iff (sys_rst)
    st_reg == apbi_pkg::ST_SPINUP && spin_ready && disk_req |=> go_reg && st_reg == apbi_pkg::ST_DISK)
    else $error("Access not started after spin-up");
  AST_DRDY: assert property (@(posedge clk) disable iff (sys_rst)
    pm_reg == apbi_pkg::PM_IDLE || pm_reg == apbi_pkg::PM_STANDBY |=> $past(pm_reg) == pm_reg -> stat_reg.drdy)
    else $error("Ready dropped while idle or standby");

endmodule : apbi_cmd_core

// ---- design/apbi_ident_rom.sv ----
// Identify parameter words 0 to 56; all higher words read zero.
// Assumes strings are packed first character in the high byte.
`timescale 1ns/1ps
module apbi_ident_rom #(
  parameter logic [159:0] SERIAL = "SERIAL NUMBER 000001",
  parameter logic [63:0] FWREV = "FW000001",
  parameter logic [319:0] MODEL = "GENERIC DISK DRIVE MODEL NUMBER 00000001",
  parameter logic [15:0] CYLS = 16'h3FFF,
  parameter logic [15:0] HEADS = 16'h0010,
  parameter logic [15:0] SPT = 16'h003F
) (
  input wire logic [7:0] idx,
  output logic [15:0] word
);
  logic [7:0] off;

  always_comb begin
    off = 8'h00;
    word = 16'h0000;
    if (idx >= apbi_pkg::ID_SER_LO && idx <= apbi_pkg::ID_SER_HI) begin
      off = idx - apbi_pkg::ID_SER_LO;
      word = SERIAL[8'(159 - 16 * off) -: 16];
    end else if (idx >= apbi_pkg::ID_FW_LO && idx <= apbi_pkg::ID_FW_HI) begin
      off = idx - apbi_pkg::ID_FW_LO;
      word = FWREV[6'(63 - 16 * off) -: 16];
    end else if (idx >= apbi_pkg::ID_MOD_LO && idx <= apbi_pkg::ID_MOD_HI) begin
      off = idx - apbi_pkg::ID_MOD_LO;
      word = MODEL[9'(319 - 16 * off) -: 16];
    end else begin
      case (idx)
        8'h00: word = apbi_pkg::ID_W0;
        8'h01: word = CYLS;
        8'h02: word = apbi_pkg::ID_W2;
        8'h03: word = HEADS;
        8'h06: word = SPT;
        8'h2F: word = apbi_pkg::ID_W47;
        8'h31: word = apbi_pkg::ID_W49;
        8'h32: word = apbi_pkg::ID_W50;
        8'h33: word = apbi_pkg::ID_W51;
        8'h35: word = apbi_pkg::ID_W53;
        8'h36: word = CYLS;
        8'h37: word = HEADS;
        8'h38: word = SPT;
        default: word = 16'h0000;
      endcase
    end
  end

endmodule : apbi_ident_rom

// ---- design/apbi_pkg.sv ----
// Shared constants and carrier types for the drive power, buffer and identify command handler.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package apbi_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SEC_S = 1;
  localparam int unsigned SEC_CYCLES = CLK_HZ * SEC_S;

  // Command codes; each power command also has an alternate code
  localparam logic [7:0] CMD_STBY_A = 8'hE2;
  localparam logic [7:0] CMD_STBY_B = 8'h96;
  localparam logic [7:0] CMD_IDLE_A = 8'hE3;
  localparam logic [7:0] CMD_IDLE_B = 8'h97;
  localparam logic [7:0] CMD_CHKP_A = 8'hE5;
  localparam logic [7:0] CMD_CHKP_B = 8'h98;
  localparam logic [7:0] CMD_SLEEP_A = 8'hE6;
  localparam logic [7:0] CMD_SLEEP_B = 8'h99;
  localparam logic [7:0] CMD_RDBUF = 8'hE4;
  localparam logic [7:0] CMD_WRBUF = 8'hE8;
  localparam logic [7:0] CMD_IDENT = 8'hEC;

  // Sector count answers
  localparam logic [7:0] SC_PM_LOW = 8'h00;
  localparam logic [7:0] SC_PM_IDLE = 8'hFF;
  localparam logic [7:0] SC_DONE = 8'h00;

  // Standby timer encoding, all periods in seconds
  localparam logic [7:0] TC_OFF = 8'h00;
  localparam logic [7:0] TC_SHORT_MAX = 8'hF0;
  localparam logic [7:0] TC_LONG_MAX = 8'hFB;
  localparam logic [7:0] TC_21M = 8'hFC;
  localparam logic [7:0] TC_HOURS = 8'hFD;
  localparam logic [7:0] TC_RSVD = 8'hFE;
  localparam logic [7:0] TC_21M15 = 8'hFF;
  localparam logic [15:0] TS_STEP_S = 16'h0005;
  localparam logic [15:0] TS_LONG_S = 16'h0708;
  localparam logic [15:0] TS_21M_S = 16'h04EC;
  localparam logic [15:0] TS_HOURS_S = 16'h8CA0;
  localparam logic [15:0] TS_21M15_S = 16'h04FB;

  // Sector and buffer geometry
  localparam int unsigned SECTOR_WORDS = 256;
  localparam logic [7:0] LAST_WORD = 8'hFF;
  localparam int unsigned BUF_WORDS = 65536;
  localparam logic [7:0] IDENT_SECTOR = 8'h00;

  // Identify words
  localparam logic [15:0] ID_W0 = 16'h0040;
  localparam logic [15:0] ID_W2 = 16'hC837;
  localparam logic [15:0] ID_W47 = 16'h8010;
  localparam logic [15:0] ID_W49 = 16'h2F00;
  localparam logic [15:0] ID_W50 = 16'h4000;
  localparam logic [15:0] ID_W51 = 16'h0200;
  localparam logic [15:0] ID_W53 = 16'h0007;
  localparam logic [7:0] ID_SER_LO = 8'h0A;
  localparam logic [7:0] ID_SER_HI = 8'h13;
  localparam logic [7:0] ID_FW_LO = 8'h17;
  localparam logic [7:0] ID_FW_HI = 8'h1A;
  localparam logic [7:0] ID_MOD_LO = 8'h1B;
  localparam logic [7:0] ID_MOD_HI = 8'h2E;

  typedef enum {ST_READY, ST_FILL, ST_PREP, ST_DRQ_RD, ST_DRQ_WR, ST_SPINUP, ST_DISK} apbi_state_e;
  typedef enum logic [1:0] {PM_IDLE, PM_STANDBY, PM_SPINUP, PM_SLEEP} apbi_pm_e;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [7:0] count;
  } apbi_cmd_s;

  typedef struct packed {
    logic bsy;
    logic drdy;
    logic drq;
    logic intrq;
  } apbi_stat_s;

endpackage : apbi_pkg

// ---- design/apbi_sby_timer.sv ----
// Standby timer: decodes the sector count code and counts whole seconds.
// Assumes sec_tick is a one-cycle pulse once per second.
`timescale 1ns/1ps
module apbi_sby_timer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic set,
  input wire logic [7:0] code,
  input wire logic restart,
  input wire logic run,
  input wire logic sec_tick,
  output logic expire
);
  logic en_reg, en_next;
  logic [15:0] per_reg, per_next;
  logic [15:0] cnt_reg, cnt_next;
  logic exp_reg, exp_next;
  logic [15:0] dec_per;
  logic dec_en;

  always_comb begin
    dec_en = 1'b1;
    dec_per = 16'h0000;
    if (code == apbi_pkg::TC_OFF || code == apbi_pkg::TC_RSVD) begin
      dec_en = 1'b0;
    end else if (code <= apbi_pkg::TC_SHORT_MAX) begin
      dec_per = 16'(code * apbi_pkg::TS_STEP_S);
    end else if (code <= apbi_pkg::TC_LONG_MAX) begin
      dec_per = 16'((code - apbi_pkg::TC_SHORT_MAX) * apbi_pkg::TS_LONG_S);
    end else if (code == apbi_pkg::TC_21M) begin
      dec_per = apbi_pkg::TS_21M_S;
    end else if (code == apbi_pkg::TC_HOURS) begin
      dec_per = apbi_pkg::TS_HOURS_S;
    end else begin
      dec_per = apbi_pkg::TS_21M15_S;
    end
  end

  always_comb begin
    en_next = en_reg;
    per_next = per_reg;
    cnt_next = cnt_reg;
    exp_next = 1'b0;
    if (set) begin
      en_next = dec_en;
      per_next = dec_per;
      cnt_next = dec_per;
    end else if (restart) begin
      cnt_next = per_reg;
    end else if (en_reg && run && sec_tick && cnt_reg != 16'h0000) begin
      cnt_next = cnt_reg - 16'h0001;
      exp_next = (cnt_reg == 16'h0001);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_reg <= 1'b0;
      per_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      exp_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
      per_reg <= per_next;
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign expire = exp_reg;

  AST_TMR_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    set && code == apbi_pkg::TC_OFF |=> !en_reg ##1 !exp_reg)
    else $error("Timer enabled by zero code");

endmodule : apbi_sby_timer

// ---- verif/apbi_cmd_core_bench.sv ----
// Testbench for the power, buffer and identify command handler.
// Assumes a 4-cycle second so the 5 s timer step lasts 20 cycles.
`timescale 1ns/1ps
module apbi_cmd_core_bench;
  logic clk, sys_rst, dev_reset, disk_req, disk_done, spin_ready, spindle_on, disk_go, rd_stb, wr_stb;
  apbi_pkg::apbi_cmd_s cmd;
  apbi_pkg::apbi_stat_s stat;
  apbi_pkg::apbi_pm_e pm;
  logic [7:0] buf_sector, sc_out;
  logic [15:0] rd_data, wr_data;
  logic [3:0] spin_cnt = 4'h0;
  logic [2:0] dpipe = 3'h0;
  int errors = 0, num_checks = 0, irqs = 0, gos = 0, n, k, lim = 100;
  localparam logic [7:0] IDX [6] = '{8'h00, 8'h2F, 8'h31, 8'h35, 8'h17, 8'h1A};
  localparam logic [15:0] EXP [6] = '{16'h0040, 16'h8010, 16'h2F00, 16'h0007, 16'h4657, 16'h3031};
  localparam logic [7:0] OFF [2] = '{8'h00, 8'hFE};
  // Long timer codes and their periods in seconds
  localparam logic [7:0] TCODE [3] = '{8'hF1, 8'hFC, 8'hFF};
  localparam logic [15:0] TSEC [3] = '{16'h0708, 16'h04EC, 16'h04FB};
  apbi_cmd_core #(.SEC_CYCLES(4)) i_dut (.clk(clk), .sys_rst(sys_rst), .dev_reset(dev_reset),
    .cmd(cmd), .buf_sector(buf_sector), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data),
    .disk_req(disk_req), .disk_done(disk_done), .spin_ready(spin_ready), .stat(stat),
    .sc_out(sc_out), .rd_data(rd_data), .spindle_on(spindle_on), .disk_go(disk_go), .pm(pm));
  apbi_host_model i_host (.clk(clk), .stat(stat), .rd_data(rd_data), .cmd(cmd),
    .buf_sector(buf_sector), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Spindle reaches speed some cycles after power; access lasts four cycles
  always @(posedge clk) begin
    if (spindle_on !== 1'b1) spin_cnt <= 4'h0;
    else if (spin_cnt != 4'hF) spin_cnt <= spin_cnt + 4'h1;
    spin_ready <= spindle_on === 1'b1 && spin_cnt > 4'h4;
    dpipe <= {dpipe[1:0], disk_go === 1'b1};
    disk_done <= dpipe[2];
    if (disk_go === 1'b1) disk_req <= 1'b0;
    if (disk_go === 1'b1) gos <= gos + 1;
    if (stat.intrq === 1'b1) irqs <= irqs + 1;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wait_st(input logic b, input logic d);
    n = 0;
    while (!(stat.bsy === b && stat.drq === d) && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n < 600), 16'h0001);
  endtask : wait_st
  // Gives up after lim cycles; n holds the wait
  task wait_pm(input apbi_pkg::apbi_pm_e p);
    n = 0;
    while (pm !== p && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_pm
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #300000;
    errors++;
    test_done;
  end
  initial begin
    sys_rst = 1'b1;
    dev_reset = 1'b0;
    disk_req = 1'b0;
    repeat (9) @(posedge clk);
    #1;
    chk(16'(pm), 16'(apbi_pkg::PM_SPINUP));
    @(posedge clk);
    sys_rst <= 1'b0;
    wait_st(1'b0, 1'b0);
    chk(16'(pm), 16'(apbi_pkg::PM_IDLE));
    chk(16'(stat.drdy), 16'h0001);
    i_host.issue(apbi_pkg::CMD_CHKP_A, 8'h00, 8'h00);
    chk(16'(sc_out), 16'h00FF);
    $display("test power_on done");
    // Interrupt counter lags the pulse by one edge
    @(posedge clk);
    #1;
    k = irqs;
    i_host.issue(apbi_pkg::CMD_IDENT, 8'h00, 8'h00);
    chk(16'(stat.bsy), 16'h0001);
    wait_st(1'b0, 1'b1);
    chk(16'(stat.intrq), 16'h0001);
    @(posedge clk);
    #1;
    chk(16'(irqs - k), 16'h0001);
    i_host.xfer(1'b0);
    chk(16'(stat.drq), 16'h0000);
    foreach (IDX[i]) chk(i_host.mem[IDX[i]], EXP[i]);
    $display("test identify done");
    for (int i = 0; i < 256; i++) i_host.mem[i] = {8'hA5, 8'(i)};
    k = irqs;
    i_host.issue(apbi_pkg::CMD_WRBUF, 8'h00, 8'h05);
    chk(16'(stat.drq), 16'h0001);
    i_host.xfer(1'b1);
    @(posedge clk);
    #1;
    chk(16'(stat.drq), 16'h0000);
    chk(16'(irqs - k), 16'h0001);
    for (int i = 0; i < 256; i++) i_host.mem[i] = 16'h0000;
    i_host.issue(apbi_pkg::CMD_RDBUF, 8'h00, 8'h05);
    chk(16'(stat.bsy), 16'h0001);
    wait_st(1'b0, 1'b1);
    chk(16'(stat.intrq), 16'h0001);
    i_host.xfer(1'b0);
    for (int i = 0; i < 256; i++) chk(i_host.mem[i], {8'hA5, 8'(i)});
    $display("test buffer done");
    i_host.issue(apbi_pkg::CMD_STBY_B, 8'h00, 8'h00);
    chk(16'({pm, spindle_on}), 16'({apbi_pkg::PM_STANDBY, 1'b0}));
    i_host.issue(apbi_pkg::CMD_CHKP_B, 8'h00, 8'h00);
    chk(16'(sc_out), 16'h0000);
    i_host.issue(apbi_pkg::CMD_IDLE_B, 8'h01, 8'h00);
    wait_pm(apbi_pkg::PM_IDLE);
    chk(16'(n < 100), 16'h0001);
    wait_pm(apbi_pkg::PM_STANDBY);
    chk(16'(n >= 16 && n <= 24 && spindle_on === 1'b0), 16'h0001);
    @(posedge clk);
    disk_req <= 1'b1;
    wait_pm(apbi_pkg::PM_SPINUP);
    chk(16'({n < 100, spindle_on}), 16'h0003);
    n = 0;
    while (gos == 0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(gos), 16'h0001);
    wait_st(1'b0, 1'b0);
    wait_pm(apbi_pkg::PM_STANDBY);
    chk(16'(n >= 16 && n <= 24), 16'h0001);
    // Each timer second is four cycles here
    lim = 8000;
    foreach (TCODE[i]) begin
      i_host.issue(apbi_pkg::CMD_IDLE_A, 8'h00, 8'h00);
      wait_pm(apbi_pkg::PM_IDLE);
      i_host.issue(apbi_pkg::CMD_IDLE_B, TCODE[i], 8'h00);
      wait_pm(apbi_pkg::PM_STANDBY);
      chk(16'(n + 4 >= 4 * TSEC[i] && n <= 4 * TSEC[i] + 4), 16'h0001);
    end
    lim = 100;
    foreach (OFF[i]) begin
      i_host.issue(apbi_pkg::CMD_IDLE_A, 8'h01, 8'h00);
      wait_pm(apbi_pkg::PM_IDLE);
      i_host.issue(apbi_pkg::CMD_IDLE_A, OFF[i], 8'h00);
      wait_pm(apbi_pkg::PM_STANDBY);
      chk(16'(n), 16'h0064);
    end
    $display("test timer done");
    k = irqs;
    i_host.issue(apbi_pkg::CMD_SLEEP_A, 8'h07, 8'h00);
    chk(16'(pm), 16'(apbi_pkg::PM_SLEEP));
    @(posedge clk);
    #1;
    chk(16'({irqs - k, stat.drdy}), 16'h0002);
    i_host.issue(apbi_pkg::CMD_CHKP_B, 8'h00, 8'h00);
    @(posedge clk);
    #1;
    chk(16'({irqs - k, pm}), 16'({2'h1, apbi_pkg::PM_SLEEP}));
    @(posedge clk);
    dev_reset <= 1'b1;
    @(posedge clk);
    dev_reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'({pm, stat.drdy}), 16'({apbi_pkg::PM_STANDBY, 1'b1}));
    $display("test sleep done");
    test_done;
  end
endmodule : apbi_cmd_core_bench

// ---- verif/apbi_host_model.sv ----
// Host model: issues commands and moves one sector of words over the strobes.
// Assumes the device shares its clock; stimulus changes by NBA just after a rising edge.
`timescale 1ns/1ps
module apbi_host_model (
  input wire logic clk,
  input wire apbi_pkg::apbi_stat_s stat,
  input wire logic [15:0] rd_data,
  output apbi_pkg::apbi_cmd_s cmd,
  output logic [7:0] buf_sector,
  output logic rd_stb,
  output logic wr_stb,
  output logic [15:0] wr_data
);
  logic [15:0] mem [256];
  initial begin
    cmd = '0;
    buf_sector = 8'h00;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    wr_data = 16'h0000;
  end
  task issue(input logic [7:0] code, input logic [7:0] cnt, input logic [7:0] sec);
    @(posedge clk);
    cmd <= '{1'b1, code, cnt};
    buf_sector <= sec;
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
  endtask : issue
  // At most one sector, never more
  task xfer(input logic wr);
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      // Host stops as soon as the device withdraws data request
      if (stat.drq !== 1'b1) break;
      if (wr) begin
        wr_data <= mem[i];
        wr_stb <= 1'b1;
      end else begin
        mem[i] = rd_data;
        rd_stb <= 1'b1;
      end
      @(posedge clk);
      rd_stb <= 1'b0;
      wr_stb <= 1'b0;
    end
    #1;
  endtask : xfer
endmodule : apbi_host_model
